// >>> core/flash_prog_timer.sv
// self-timed programming cycle counter
`timescale 1ns/1ps
`default_nettype none
module flash_prog_timer
   import flash_table_pkg::*;
#(
   parameter int CYCLES = PROG_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start,
   output logic      done
);
   logic [31:0] count;
   logic        running;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count   <= 32'h0000_0000;
         running <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !running) begin
            running <= 1'b1;
            count   <= 32'h0000_0000;
         end else if (running) begin
            if (count == 32'(CYCLES - 1)) begin
               running <= 1'b0;
               done    <= 1'b1;
            end else begin
               count <= count + 32'h0000_0001;
            end
         end
      end
   end
endmodule // flash_prog_timer
`default_nettype wire

// >>> core/flash_table_access_ctrl.sv
// flash table pointer, latch, holding block and self-timed erase/write unit
// Behaviour
// - write-control starts timed cycle, hardware clears it
// - software may only set write-control
// - memory and config selects kept on error; reset clears both
// - 8-bit table latch readable and writable
// - three pointer bytes form 22-bit address
// - low 21 bits program, top bit config
// - auto updates touch only low 21 bits
// - four pointer modes per table access
// - table read fetches byte into latch
// - table write loads holding register by low bits
// - upper pointer bits ignored on table write
// - block write uses upper pointer bits only
// - erase clears 64-byte block, ignores bits 5:0
// - address lsb picks word high or low byte
// - no word erase, 32-word minimum
// - start accepted only after unlock sequence
// - core halted during long cycle
// - holding bytes FFh after reset and write
// - error flag on aborted or improper write
// - erase select cleared when erase completes
`timescale 1ns/1ps
`default_nettype none
module flash_table_access_ctrl
   import flash_table_pkg::*;
#(
   // block size 8, 16 or 32
   parameter int BLOCK_BYTES = 16,
   parameter int PROG_CYC    = PROG_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        table_read_instr,
   input  wire logic        table_write_instr,
   input  wire logic [1:0]  table_ptr_mode,
   output logic             core_stall,
   output logic             table_done
);
   localparam int SEL_W = $clog2(BLOCK_BYTES);
   localparam int WORDS = 1 << PMEM_ADDR_W;

   ////////////////////////////////////////////////////////////////////////
   logic [15:0]            pmem [WORDS];
   logic [7:0]             hold [BLOCK_BYTES];
   logic [PTR_W-1:0]       table_pointer;
   logic [7:0]             table_latch_byte;
   logic                   program_memory_select;
   logic                   config_space_select;
   logic                   erase_select;
   logic                   write_error_flag;
   logic                   write_enable_bit;
   logic                   write_ctrl;
   logic [1:0]             unlock_stage;
   prog_state_t            state;
   logic                   timer_start;
   logic                   timer_done;
   logic                   first_cycle;
   logic [PMEM_ADDR_W-1:0] sweep;
   logic                   sweep_busy;
   logic                   rd_pending;
   logic [1:0]             pend_mode;
   logic                   pend_write;

   wire logic wr_access = psel && penable && pwrite;
   wire logic rd_access = psel && penable && !pwrite;
   wire logic sw_table  = wr_access && paddr == OFF_TABLE_CMD && pwdata[CMD_GO_BIT];
   wire logic go        = (table_read_instr || table_write_instr || sw_table) && state == ST_IDLE;
   wire logic go_write  = sw_table ? pwdata[CMD_WRITE_BIT] : table_write_instr;
   wire logic [1:0] go_mode = sw_table ? pwdata[1:0] : table_ptr_mode;

   // step on low 21 bits only, keep top bit
   function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic dec);
      logic [PTR_LOW_BITS-1:0] low;
      low = dec ? p[PTR_LOW_BITS-1:0] - 21'd1 : p[PTR_LOW_BITS-1:0] + 21'd1;
      return {p[PTR_W-1], low};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait, unmapped reads zero with error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pready <= 1'b1;
      else
         pready <= 1'b1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= paddr > OFF_STATUS || paddr[1:0] != 2'b00;
         case (paddr)
            OFF_CONTROL_ONE: prdata <= {24'h00_0000, program_memory_select, config_space_select, 1'b0,
                                        erase_select, write_error_flag, write_enable_bit, write_ctrl, 1'b0};
            OFF_LATCH:       prdata <= {24'h00_0000, table_latch_byte};
            OFF_PTR_LOW:     prdata <= {24'h00_0000, table_pointer[7:0]};
            OFF_PTR_HIGH:    prdata <= {24'h00_0000, table_pointer[15:8]};
            OFF_PTR_UPPER:   prdata <= {26'h000_0000, table_pointer[21:16]};
            OFF_STATUS:      prdata <= {30'h0000_0000, state != ST_IDLE, rd_pending};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // unlock sequence tracker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_stage <= 2'b00;
      end else if (wr_access) begin
         // 55h then AAh arms one start
         if (paddr == OFF_UNLOCK && pwdata[7:0] == UNLOCK_FIRST)
            unlock_stage <= 2'b01;
         else if (paddr == OFF_UNLOCK && pwdata[7:0] == UNLOCK_SECOND && unlock_stage == 2'b01)
            unlock_stage <= 2'b10;
         else
            unlock_stage <= 2'b00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register and programming state machine
   wire logic ctl_wr     = wr_access && paddr == OFF_CONTROL_ONE;
   wire logic start_req  = ctl_wr && pwdata[BIT_WR_CTRL] && !write_ctrl;
   wire logic start_ok   = start_req && unlock_stage == 2'b10 && write_enable_bit
                           && pwdata[BIT_WR_EN] && pwdata[BIT_PGM_SEL];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_memory_select <= 1'b0;
         config_space_select   <= 1'b0;
         erase_select          <= 1'b0;
         write_enable_bit      <= 1'b0;
         write_ctrl            <= 1'b0;
         state                 <= ST_IDLE;
         timer_start           <= 1'b0;
         core_stall            <= 1'b0;
      end else begin
         timer_start <= 1'b0;
         if (ctl_wr && state == ST_IDLE) begin
            program_memory_select <= pwdata[BIT_PGM_SEL];
            config_space_select   <= pwdata[BIT_CFG_SEL];
            erase_select          <= pwdata[BIT_ERASE_SEL];
            write_enable_bit      <= pwdata[BIT_WR_EN];
         end
         case (state)
            ST_IDLE: begin
               if (start_ok) begin
                  write_ctrl  <= 1'b1;
                  timer_start <= 1'b1;
                  core_stall  <= 1'b1;
                  state       <= pwdata[BIT_ERASE_SEL] ? ST_ERASE : ST_WRITE;
               end
            end
            ST_ERASE, ST_WRITE: begin
               if (timer_done) begin
                  write_ctrl <= 1'b0;
                  core_stall <= 1'b0;
                  if (state == ST_ERASE)
                     erase_select <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // error flag: async reset cannot tell abort, so it powers up set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_error_flag <= 1'b1;
      end else if (start_req && !start_ok) begin
         write_error_flag <= 1'b1;
      end else if (timer_done) begin
         write_error_flag <= 1'b0;
      end
   end

   flash_prog_timer #(
      .CYCLES (PROG_CYC)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (timer_start),
      .done    (timer_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // table pointer and latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_pointer    <= 22'h00_0000;
         table_latch_byte <= 8'h00;
         rd_pending       <= 1'b0;
         pend_mode        <= 2'b00;
         pend_write       <= 1'b0;
         table_done       <= 1'b0;
         first_cycle      <= 1'b0;
      end else begin
         table_done <= 1'b0;
         if (wr_access && paddr == OFF_LATCH)
            table_latch_byte <= pwdata[7:0];
         if (wr_access && paddr == OFF_PTR_LOW)
            table_pointer[7:0] <= pwdata[7:0];
         if (wr_access && paddr == OFF_PTR_HIGH)
            table_pointer[15:8] <= pwdata[7:0];
         if (wr_access && paddr == OFF_PTR_UPPER)
            table_pointer[21:16] <= pwdata[5:0];
         if (go) begin
            if (go_mode == PTR_PRE_INC)
               table_pointer <= ptr_step(table_pointer, 1'b0);
            rd_pending <= 1'b1;
            pend_mode  <= go_mode;
            pend_write <= go_write;
         end else if (rd_pending) begin
            rd_pending <= 1'b0;
            table_done <= 1'b1;
            if (!pend_write) begin
               // lsb picks high or low byte
               // top bit selects config space, reads blank
               if (table_pointer[PTR_W-1])
                  table_latch_byte <= HOLD_RESET;
               else if (table_pointer[0])
                  table_latch_byte <= pmem[table_pointer[PMEM_ADDR_W:1]][15:8];
               else
                  table_latch_byte <= pmem[table_pointer[PMEM_ADDR_W:1]][7:0];
            end
            if (pend_mode == PTR_POST_INC)
               table_pointer <= ptr_step(table_pointer, 1'b0);
            else if (pend_mode == PTR_POST_DEC)
               table_pointer <= ptr_step(table_pointer, 1'b1);
         end
         first_cycle <= timer_start;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // holding registers
   genvar g;
   generate
      for (g = 0; g < BLOCK_BYTES; g++) begin : g_hold
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hold[g] <= HOLD_RESET;
            end else if (timer_done && state == ST_WRITE) begin
               hold[g] <= HOLD_RESET;
            end else if (rd_pending && pend_write && table_pointer[SEL_W-1:0] == SEL_W'(g)) begin
               hold[g] <= table_latch_byte;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // flash array update: block write at end of long cycle, erase sweep from its start
   always_ff @(posedge pclk) begin
      if (timer_done && state == ST_WRITE && !config_space_select && !table_pointer[PTR_W-1]) begin
         // block base from upper bits only
         for (int i = 0; i < BLOCK_BYTES; i += 2) begin
            pmem[{table_pointer[PMEM_ADDR_W:SEL_W], (SEL_W-1)'(i / 2)}] <=
               pmem[{table_pointer[PMEM_ADDR_W:SEL_W], (SEL_W-1)'(i / 2)}] & {hold[i+1], hold[i]};
         end
      end else if (sweep_busy) begin
         pmem[sweep] <= 16'hFFFF;
      end
   end

   // erase walks the 32 words of one 64-byte block
   // smallest erase unit, no word erase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sweep      <= '0;
         sweep_busy <= 1'b0;
      end else if (first_cycle && state == ST_ERASE && !config_space_select && !table_pointer[PTR_W-1]) begin
         sweep      <= {table_pointer[PMEM_ADDR_W:ERASE_BITS], 5'h00};
         sweep_busy <= 1'b1;
      end else if (sweep_busy) begin
         sweep      <= sweep + 14'h0001;
         sweep_busy <= sweep[4:0] != 5'h1F;
      end
   end
endmodule // flash_table_access_ctrl
`default_nettype wire

// >>> core/flash_table_pkg.sv
// constants for the flash table access unit
package flash_table_pkg;
   // register byte offsets on apb
   localparam logic [7:0] OFF_CONTROL_ONE    = 8'h00;
   localparam logic [7:0] OFF_UNLOCK         = 8'h04;
   localparam logic [7:0] OFF_LATCH          = 8'h08;
   localparam logic [7:0] OFF_PTR_LOW        = 8'h0C;
   localparam logic [7:0] OFF_PTR_HIGH       = 8'h10;
   localparam logic [7:0] OFF_PTR_UPPER      = 8'h14;
   localparam logic [7:0] OFF_TABLE_CMD      = 8'h18;
   localparam logic [7:0] OFF_STATUS         = 8'h1C;
   // control register bit positions
   localparam int BIT_PGM_SEL    = 7;
   localparam int BIT_CFG_SEL    = 6;
   localparam int BIT_ERASE_SEL  = 4;
   localparam int BIT_WR_ERR     = 3;
   localparam int BIT_WR_EN      = 2;
   localparam int BIT_WR_CTRL    = 1;
   // table command register fields
   localparam int CMD_GO_BIT     = 2;
   localparam int CMD_WRITE_BIT  = 3;
   // pointer geometry
   localparam int PTR_W          = 22;
   localparam int PTR_LOW_BITS   = 21;
   localparam int ERASE_BITS     = 6;
   localparam int ERASE_BYTES    = 64;
   localparam int PMEM_ADDR_W    = 14;
   // reset and unlock values
   localparam logic [7:0] HOLD_RESET      = 8'hFF;
   localparam logic [7:0] UNLOCK_FIRST    = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND   = 8'hAA;
   // programming timer (about 2 ms)
   localparam int PROG_TIME_US    = 2000;
   localparam int CLK_MHZ         = 100;
   localparam int PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
   // pointer update modes
   typedef enum logic [1:0] {
      PTR_KEEP     = 2'b00,
      PTR_POST_INC = 2'b01,
      PTR_POST_DEC = 2'b10,
      PTR_PRE_INC  = 2'b11
   } ptr_mode_t;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ERASE = 2'b01,
      ST_WRITE = 2'b10
   } prog_state_t;
endpackage

// >>> verif/core_model.sv
// core model issuing table read and write pulses
`timescale 1ns/1ps
`default_nettype none
module core_model
   import flash_table_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       table_done,
   output logic            table_read_instr,
   output logic            table_write_instr,
   output logic [1:0]      table_ptr_mode
);
   ////////////////////
   initial begin
      table_read_instr  <= 1'b0;
      table_write_instr <= 1'b0;
      table_ptr_mode    <= PTR_KEEP;
   end
   task automatic access(input logic wr, input ptr_mode_t m);
      @(posedge pclk);
      table_read_instr  <= ~wr;
      table_write_instr <= wr;
      table_ptr_mode    <= m;
      @(posedge pclk);
      table_read_instr  <= 1'b0;
      table_write_instr <= 1'b0;
      table_ptr_mode    <= ~m;
      do @(posedge pclk); while (table_done !== 1'b1);
   endtask
endmodule // core_model
`default_nettype wire

// >>> verif/flash_table_access_ctrl_properties.sv
// port checker for the flash table access unit
`timescale 1ns/1ps
`default_nettype none
module flash_table_access_ctrl_properties
   import flash_table_pkg::*;
#(
   parameter int PROG_CYC = PROG_CYCLES
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        table_read_instr,
   input wire logic        table_write_instr,
   input wire logic [1:0]  table_ptr_mode,
   input wire logic        core_stall,
   input wire logic        table_done
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////
   logic [31:0] stall_cnt;
   wire logic   req = table_read_instr | table_write_instr;
   wire logic   acc = psel & penable;
   wire logic   bad = (paddr > 8'h1C) || (paddr[1:0] != 2'b00);
   wire logic   rd_ctrl = acc & ~pwrite & (paddr == OFF_CONTROL_ONE);
   wire logic   set_ctrl = acc & pwrite & (paddr == OFF_CONTROL_ONE) & pwdata[BIT_WR_CTRL];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stall_cnt <= '0;
      else if (core_stall) stall_cnt <= stall_cnt + 32'h1;
      else stall_cnt <= '0;
   end
   ////////////////////
   chk_zero_wait: assert property (pready) else $error("pready low");
   chk_slverr_bad: assert property (acc && bad |-> pslverr) else $error("no slverr");
   chk_slverr_good: assert property (acc && !bad |-> !pslverr) else $error("stray slverr");
   chk_bad_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0) else $error("bad read data");
   chk_stall_cause: assert property ($rose(core_stall) |-> $past(set_ctrl)) else $error("stall w/o start");
   chk_stall_length: assert property ($fell(core_stall) |-> stall_cnt == PROG_CYC + 2) else $error("stall len");
   chk_busy_bit: assert property (rd_ctrl && core_stall == $past(core_stall)
      |-> prdata[BIT_WR_CTRL] == core_stall) else $error("write ctrl bit");
   chk_done_pulse: assert property (table_done |=> !table_done) else $error("done too long");
   chk_done_follows: assert property (req && !core_stall |-> ##[1:2] table_done) else $error("no done");
   chk_done_cause: assert property ($rose(table_done) |-> $past(req) || $past(req, 2)) else $error("stray done");
   chk_halt_quiet: assert property (core_stall && $past(core_stall) |-> !table_done) else $error("done in halt");
   cover property ($fell(core_stall));
   cover property (table_done);
   cover property (acc && pslverr);
endmodule // flash_table_access_ctrl_properties
bind flash_table_access_ctrl flash_table_access_ctrl_properties #(.PROG_CYC(PROG_CYC)) i_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .table_read_instr(table_read_instr), .table_write_instr(table_write_instr),
   .table_ptr_mode(table_ptr_mode), .core_stall(core_stall), .table_done(table_done));
`default_nettype wire

// >>> verif/flash_table_access_ctrl_tb_top.sv
// testbench for the flash table access unit
`timescale 1ns/1ps
`default_nettype none
module flash_table_access_ctrl_tb_top
   import flash_table_pkg::*;
;
   localparam int PCYC = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        rd_i, wr_i, core_stall, table_done;
   logic [1:0]  mode;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   int          num_errors, checks_done;
   int          cycles = 0;
   ptr_mode_t   ms[3] = '{PTR_KEEP, PTR_POST_DEC, PTR_PRE_INC};
   logic [21:0] pe[3] = '{22'h000041, 22'h000040, 22'h000041};
   ////////////////////
   flash_table_access_ctrl #(.BLOCK_BYTES(16), .PROG_CYC(PCYC)) i_flash_table_access_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .table_read_instr(rd_i), .table_write_instr(wr_i), .table_ptr_mode(mode),
      .core_stall(core_stall), .table_done(table_done));
   core_model i_core_model (.pclk(pclk), .table_done(table_done), .table_read_instr(rd_i),
      .table_write_instr(wr_i), .table_ptr_mode(mode));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////
   task automatic finish_test();
      if (num_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;
   endtask
   task automatic set_ptr(input logic [21:0] p);
      apb(1'b1, OFF_PTR_UPPER, {26'h0, p[21:16]});
      apb(1'b1, OFF_PTR_HIGH, {24'h0, p[15:8]});
      apb(1'b1, OFF_PTR_LOW, {24'h0, p[7:0]});
   endtask
   task automatic chk_ptr(input logic [21:0] e);
      logic [21:0] p;
      apb(1'b0, OFF_PTR_UPPER, 32'h0);
      p[21:16] = q[5:0];
      apb(1'b0, OFF_PTR_HIGH, 32'h0);
      p[15:8] = q[7:0];
      apb(1'b0, OFF_PTR_LOW, 32'h0);
      p[7:0] = q[7:0];
      check("pointer", {10'h0, p}, {10'h0, e});
   endtask
   task automatic long_op(input logic [7:0] c);
      apb(1'b1, OFF_CONTROL_ONE, {24'h0, c & 8'hFD});
      apb(1'b1, OFF_UNLOCK, {24'h0, UNLOCK_FIRST});
      apb(1'b1, OFF_UNLOCK, {24'h0, UNLOCK_SECOND});
      apb(1'b1, OFF_CONTROL_ONE, {24'h0, c});
      @(posedge pclk);
      check("stall", {31'h0, core_stall}, 32'h1);
      apb(1'b1, OFF_CONTROL_ONE, 32'h0);
      apb(1'b0, OFF_CONTROL_ONE, 32'h0);
      check("wr_held", {31'h0, q[BIT_WR_CTRL]}, 32'h1);
      apb(1'b0, OFF_STATUS, 32'h0);
      check("busy", {31'h0, q[1]}, 32'h1);
      while (core_stall !== 1'b0) @(posedge pclk);
   endtask
   ////////////////////
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      num_errors = 0;
      checks_done = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_CONTROL_ONE, 32'h0);
      check("ctrl_reset", q, 32'h08);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped", {31'h0, err}, 32'h1);
      set_ptr(22'h3FFFFF);
      i_core_model.access(1'b0, PTR_POST_INC);
      chk_ptr(22'h200000);
      apb(1'b0, OFF_LATCH, 32'h0);
      check("config_byte", q, 32'hFF);
      apb(1'b1, OFF_CONTROL_ONE, 32'h84);
      apb(1'b1, OFF_CONTROL_ONE, 32'h86);
      apb(1'b0, OFF_CONTROL_ONE, 32'h0);
      check("improper", q, 32'h8C);
      check("no_stall", {31'h0, core_stall}, 32'h0);
      set_ptr(22'h000055);
      long_op(8'h96);
      apb(1'b0, OFF_CONTROL_ONE, 32'h0);
      check("erase_done", q, 32'h84);
      apb(1'b1, OFF_LATCH, 32'hA5);
      apb(1'b0, OFF_LATCH, 32'h0);
      check("latch", q, 32'hA5);
      set_ptr(22'h003C40);
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, OFF_LATCH, 32'h30 + i);
         i_core_model.access(1'b1, PTR_POST_INC);
      end
      chk_ptr(22'h003C50);
      set_ptr(22'h00004F);
      long_op(8'h86);
      long_op(8'h86);
      set_ptr(22'h000040);
      for (int i = 0; i < 17; i++) begin
         i_core_model.access(1'b0, PTR_POST_INC);
         apb(1'b0, OFF_LATCH, 32'h0);
         check("readback", q, (i < 16) ? 32'h30 + i : 32'hFF);
      end
      set_ptr(22'h000041);
      for (int k = 0; k < 3; k++) begin
         i_core_model.access(1'b0, ms[k]);
         apb(1'b0, OFF_LATCH, 32'h0);
         check("mode_byte", q, 32'h31);
         chk_ptr(pe[k]);
      end
      finish_test();
   end
endmodule // flash_table_access_ctrl_tb_top
`default_nettype wire
